// ### lcti_defines.svh
`ifndef LCTI_DEFINES_SVH
`define LCTI_DEFINES_SVH

// target address: upper three bits fixed high, lowest fixed low
`define LCTI_ADDR_HI        3'h7
`define LCTI_ADDR_LO        1'h0
`define LCTI_BYTE_BITS      4'h8
// link clock half period in system clocks: 100 kHz standard mode
`define LCTI_SYS_NS         20
`define LCTI_SCL_HALF_NS    5000
`define LCTI_SCL_HALF_CYC   (`LCTI_SCL_HALF_NS / `LCTI_SYS_NS)
`define LCTI_POR_MS         500
`define LCTI_POR_CYC        ((`LCTI_POR_MS * 1000000) / `LCTI_SYS_NS)
`define LCTI_CFG_BYTES      8

`endif

// ### lcti_pkg.sv
package lcti_pkg;
   typedef enum logic [2:0] {
      TS_IDLE,
      TS_ADDR,
      TS_ACK,
      TS_WRITE,
      TS_READ,
      TS_RACK
   } lcti_tstate_t;

   typedef enum logic [3:0] {
      CS_IDLE,
      CS_START,
      CS_BIT_LO,
      CS_BIT_HI,
      CS_ACK_LO,
      CS_ACK_HI,
      CS_STOP_LO,
      CS_STOP_HI,
      CS_STOP_END
   } lcti_cstate_t;
endpackage : lcti_pkg

// ### lcti_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lcti_bus_if;
   logic scl_o;
   logic scl_oe;
   logic sda_o;
   logic sda_oe;
   logic sda_t_o;
   logic sda_t_oe;
   logic scl_t_oe;
   // open drain wired level with pull-up
   logic scl;
   logic sda;
   assign scl = !((scl_oe && !scl_o) || (scl_t_oe && 1'b0));
   assign sda = !((sda_oe && !sda_o) || (sda_t_oe && !sda_t_o));

   modport ctrl (
      output scl_o, scl_oe, sda_o, sda_oe,
      input  scl, sda
   );
   modport target (
      output sda_t_o, sda_t_oe, scl_t_oe,
      input  scl, sda
   );
endinterface : lcti_bus_if
`default_nettype wire

// ### lcti_target.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcti_defines.svh"
module lcti_target
   import lcti_pkg::*;
#(
   parameter int POR_CYC   = `LCTI_POR_CYC,
   parameter int NUM_BYTES = `LCTI_CFG_BYTES
) (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_ce,
   input  wire logic                 i_config_source_select,
   input  wire logic [2:0]           i_addr_sel,
   output logic [NUM_BYTES*8-1:0]    o_cfg,
   output logic                      o_ready,
   lcti_bus_if.target                bus
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [1:0]                scl_s;
      logic [1:0]                sda_s;
      logic [1:0]                sel_s;
      logic [2:0]                adr_s0;
      logic [2:0]                adr_s1;
      logic                      scl_d;
      logic                      sda_d;
      lcti_tstate_t              st;
      logic [3:0]                bitn;
      logic [7:0]                sh;
      logic                      rw;
      logic                      have_idx;
      logic [7:0]                idx;
      logic                      sda_drv;
      logic [31:0]               por;
      logic [NUM_BYTES*8-1:0]    mem;
   } lcti_tgt_t;

   lcti_tgt_t r;
   lcti_tgt_t next_r;

   logic scl_v;
   logic sda_v;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic ready;
   logic sel_v;
   logic [2:0] adr_v;

   function automatic logic [7:0] rd_byte(input logic [NUM_BYTES*8-1:0] m,
                                          input logic [7:0] i);
      rd_byte = (i < 8'(NUM_BYTES)) ? m[i*8 +: 8] : 8'h00;
   endfunction

   function automatic logic [6:0] own_addr(input logic [2:0] sel);
      own_addr = {`LCTI_ADDR_HI, sel, `LCTI_ADDR_LO};
   endfunction

   // ==========================================================
   // pin sampling and edge detection
   assign scl_v    = r.scl_s[1];
   assign sda_v    = r.sda_s[1];
   assign scl_rise = scl_v && !r.scl_d;
   assign scl_fall = !scl_v && r.scl_d;
   assign start_c  = scl_v && r.scl_d && r.sda_d && !sda_v;
   assign stop_c   = scl_v && r.scl_d && !r.sda_d && sda_v;
   // strap pins pass two flip-flops like the bus lines
   assign sel_v    = r.sel_s[1];
   assign adr_v    = r.adr_s1;
   assign ready    = (r.por >= 32'(POR_CYC)) && sel_v;

   // ==========================================================
   // byte engine
   always_comb begin
      next_r          = r;
      next_r.scl_s    = {r.scl_s[0], bus.scl};
      next_r.sda_s    = {r.sda_s[0], bus.sda};
      next_r.sel_s    = {r.sel_s[0], i_config_source_select};
      next_r.adr_s0   = i_addr_sel;
      next_r.adr_s1   = r.adr_s0;
      next_r.scl_d    = scl_v;
      next_r.sda_d    = sda_v;
      if (r.por < 32'(POR_CYC)) begin
         next_r.por = r.por + 32'h0000_0001;
      end
      if (!ready || stop_c) begin
         next_r.st      = TS_IDLE;
         next_r.sda_drv = 1'b0;
      end else if (start_c) begin
         next_r.st       = TS_ADDR;
         next_r.bitn     = 4'h0;
         next_r.sda_drv  = 1'b0;
         next_r.have_idx = 1'b0;
      end else begin
         unique case (r.st)
            TS_IDLE: ;
            TS_ADDR, TS_WRITE: begin
               if (scl_rise) begin
                  next_r.sh   = {r.sh[6:0], sda_v};
                  next_r.bitn = r.bitn + 4'h1;
               end
               if (scl_fall && r.bitn == `LCTI_BYTE_BITS) begin
                  next_r.bitn = 4'h0;
                  if (r.st == TS_ADDR) begin
                     if (r.sh[7:1] == own_addr(adr_v)) begin
                        next_r.rw      = r.sh[0];
                        next_r.st      = TS_ACK;
                        next_r.sda_drv = 1'b1;
                     end else begin
                        next_r.st = TS_IDLE;
                     end
                  end else begin
                     next_r.st      = TS_ACK;
                     next_r.sda_drv = 1'b1;
                     if (!r.have_idx) begin
                        next_r.idx      = r.sh;
                        next_r.have_idx = 1'b1;
                     end else begin
                        if (r.idx < 8'(NUM_BYTES)) begin
                           next_r.mem[r.idx*8 +: 8] = r.sh;
                        end
                        next_r.idx = r.idx + 8'h01;
                     end
                  end
               end
            end
            TS_ACK: begin
               // low held through the ninth clock high phase
               if (scl_fall) begin
                  if (r.rw) begin
                     next_r.st      = TS_READ;
                     next_r.sh      = rd_byte(r.mem, r.idx);
                     next_r.sda_drv = !next_r.sh[7];
                     next_r.bitn    = 4'h1;
                  end else begin
                     next_r.st      = TS_WRITE;
                     next_r.sda_drv = 1'b0;
                  end
               end
            end
            TS_READ: begin
               if (scl_fall) begin
                  if (r.bitn == `LCTI_BYTE_BITS) begin
                     next_r.st      = TS_RACK;
                     next_r.sda_drv = 1'b0;
                     next_r.idx     = r.idx + 8'h01;
                  end else begin
                     next_r.sh      = {r.sh[6:0], 1'b0};
                     next_r.sda_drv = !r.sh[6];
                     next_r.bitn    = r.bitn + 4'h1;
                  end
               end
            end
            TS_RACK: begin
               if (scl_rise) begin
                  // controller nack ends the read
                  next_r.st = sda_v ? TS_IDLE : TS_ACK;
               end
            end
            default: next_r.st = TS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         r       <= '0;
         r.scl_s <= 2'b11;
         r.sda_s <= 2'b11;
         r.scl_d <= 1'b1;
         r.sda_d <= 1'b1;
         r.st    <= TS_IDLE;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   // ==========================================================
   // outputs
   assign bus.sda_t_o  = 1'b0;
   assign bus.sda_t_oe = r.sda_drv;
   assign bus.scl_t_oe = 1'b0;
   assign o_cfg        = r.mem;
   assign o_ready      = ready;
endmodule : lcti_target
`default_nettype wire

// ### lcti_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "lcti_defines.svh"
module lcti_ctrl
   import lcti_pkg::*;
#(
   parameter int HALF_CYC = `LCTI_SCL_HALF_CYC
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_ce,
   input  wire logic          i_start,
   input  wire logic [7:0]    i_tx_byte,
   input  wire logic          i_read,
   input  wire logic          i_last,
   output logic               o_busy,
   output logic               o_byte_done,
   output logic [7:0]         o_rx_byte,
   output logic               o_ack,
   lcti_bus_if.ctrl           bus
);
   // ==========================================================
   // state: i_start opens a frame with start, the byte i_tx_byte
   // (address); each o_byte_done takes next i_tx_byte/i_read/i_last
   typedef struct packed {
      lcti_cstate_t st;
      logic [15:0]  cnt;
      logic [3:0]   bitn;
      logic [7:0]   sh;
      logic         rd;
      logic         last;
      logic         scl;
      logic         sda;
      logic         done;
      logic [7:0]   rx;
      logic         ack;
      logic [1:0]   sda_s;
   } lcti_ctl_t;

   lcti_ctl_t r;
   lcti_ctl_t next_r;
   logic      tick;

   assign tick = (r.cnt == 16'(HALF_CYC - 1));

   always_comb begin
      next_r       = r;
      next_r.done  = 1'b0;
      next_r.sda_s = {r.sda_s[0], bus.sda};
      next_r.cnt   = tick ? 16'h0000 : r.cnt + 16'h0001;
      if (r.st == CS_IDLE) begin
         next_r.cnt = 16'h0000;
      end
      unique case (r.st)
         CS_IDLE: if (i_start) begin
            next_r.st   = CS_START;
            next_r.sda  = 1'b0;
            next_r.sh   = i_tx_byte;
            next_r.rd   = 1'b0;
            next_r.last = i_last;
            next_r.bitn = 4'h0;
         end
         CS_START: if (tick) begin
            next_r.st  = CS_BIT_LO;
            next_r.scl = 1'b0;
         end
         CS_BIT_LO: if (tick) begin
            next_r.st  = CS_BIT_HI;
            next_r.scl = 1'b1;
         end else if (r.cnt == 16'h0000) begin
            next_r.sda = r.rd ? 1'b1 : r.sh[7];
         end
         CS_BIT_HI: if (tick) begin
            next_r.scl  = 1'b0;
            next_r.sh   = {r.sh[6:0], r.sda_s[1]};
            next_r.bitn = r.bitn + 4'h1;
            next_r.st   = (r.bitn == `LCTI_BYTE_BITS - 4'h1) ?
                          CS_ACK_LO : CS_BIT_LO;
         end
         CS_ACK_LO: if (tick) begin
            next_r.st  = CS_ACK_HI;
            next_r.scl = 1'b1;
         end else if (r.cnt == 16'h0000) begin
            // read: ack all but the final byte
            next_r.sda = r.rd ? r.last : 1'b1;
         end
         CS_ACK_HI: if (tick) begin
            next_r.scl  = 1'b0;
            next_r.done = 1'b1;
            next_r.rx   = r.sh;
            next_r.ack  = r.rd ? !r.last : !r.sda_s[1];
            next_r.bitn = 4'h0;
            // stop after the final byte or a refused write byte
            if (r.last || (!r.rd && r.sda_s[1])) begin
               next_r.st = CS_STOP_LO;
            end else begin
               next_r.st   = CS_BIT_LO;
               next_r.sh   = i_tx_byte;
               next_r.rd   = i_read;
               next_r.last = i_last;
            end
         end
         CS_STOP_LO: if (tick) begin
            next_r.st  = CS_STOP_HI;
            next_r.scl = 1'b1;
         end else if (r.cnt == 16'h0000) begin
            next_r.sda = 1'b0;
         end
         CS_STOP_HI: if (tick) begin
            next_r.st  = CS_STOP_END;
            next_r.sda = 1'b1;
         end
         CS_STOP_END: if (tick) begin
            next_r.st = CS_IDLE;
         end
         default: next_r.st = CS_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         r       <= '0;
         r.st    <= CS_IDLE;
         r.scl   <= 1'b1;
         r.sda   <= 1'b1;
         r.sda_s <= 2'b11;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   assign bus.scl_o    = 1'b0;
   assign bus.scl_oe   = !r.scl;
   assign bus.sda_o    = 1'b0;
   assign bus.sda_oe   = !r.sda;
   assign o_busy       = (r.st != CS_IDLE);
   assign o_byte_done  = r.done;
   assign o_rx_byte    = r.rx;
   assign o_ack        = r.ack;
endmodule : lcti_ctrl
`default_nettype wire

// ### lcti_bus_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module lcti_bus_asserts #(
   parameter logic [6:0] TADDR = 7'h7a
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_config_source_select,
   input wire logic sda_oe,
   input wire logic sda_t_o,
   input wire logic sda_t_oe,
   input wire logic scl_t_oe,
   input wire logic scl,
   input wire logic sda
);
   // ========
   // wire tracker: bit count, first byte, address match, direction
   typedef struct packed {
      logic [3:0] cnt;
      logic [7:0] sh;
      logic       first;
      logic       match;
      logic       rd;
      logic       scl_q;
      logic       sda_q;
   } lcti_mon_t;
   lcti_mon_t st;
   lcti_mon_t next_st;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   always_comb begin
      next_st = st;
      next_st.scl_q = scl;
      next_st.sda_q = sda;
      if (scl && !st.scl_q) begin
         next_st.sh = {st.sh[6:0], sda};
         next_st.cnt = (st.cnt == 4'h9) ? 4'h1 : st.cnt + 4'h1;
         next_st.first = st.first && (st.cnt != 4'h9);
      end
      if (st.first && st.cnt == 4'h8) begin
         next_st.match = (st.sh[7:1] == TADDR) && i_config_source_select;
         next_st.rd = st.sh[0];
      end
      if (scl && st.scl_q && st.sda_q && !sda) begin
         next_st.cnt = 4'h0;
         next_st.first = 1'b1;
         next_st.match = 1'b0;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   a_no_stretch: assert property (!scl_t_oe)
      else $error("target drove the clock");
   a_hold_high: assert property (
      scl && $past(scl) |->
      $stable(sda_t_oe) && (!sda_t_oe || $stable(sda_t_o)))
      else $error("target data moved while clock high");
   a_addr_ack: assert property (
      scl && st.scl_q && st.cnt == 4'h9 && st.first |-> sda == !st.match)
      else $error("address acknowledge wrong");
   a_write_ack: assert property (
      scl && st.scl_q && st.cnt == 4'h9 && !st.first && st.match &&
      !st.rd |-> !sda)
      else $error("write byte not acknowledged");
   a_read_release: assert property (
      scl && st.scl_q && st.cnt == 4'h9 && !st.first && st.rd |->
      !sda_t_oe)
      else $error("target held data in read acknowledge");
   a_ctrl_release: assert property (
      scl && st.scl_q && st.cnt == 4'h9 && (st.first || !st.rd) |->
      !sda_oe)
      else $error("controller held data in acknowledge");
   a_stray_quiet: assert property (!st.match |-> !sda_t_oe)
      else $error("unaddressed target drove data");
   a_stop_release: assert property (
      scl && $past(scl) && $rose(sda) |-> !sda_t_oe [*8])
      else $error("target drove data after stop");
   a_start_quiet: assert property (
      scl && $past(scl) && $fell(sda) |=> !sda_t_oe [*8])
      else $error("target drove data after start");
endmodule // lcti_bus_asserts
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
`define LCTI_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   mismatches++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb;
   localparam logic [6:0] TADDR = 7'h7a;
   localparam logic [6:0] BAD [4] = '{7'h72, 7'h7b, 7'h5a, 7'h3a};
   logic        i_sys_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_start = 1'b0;
   logic        i_read = 1'b0;
   logic        i_last = 1'b0;
   logic        i_config_source_select = 1'b1;
   logic        i_ce = 1'b1;
   logic [2:0]  i_addr_sel = 3'h5;
   logic [7:0]  i_tx_byte = 8'h00;
   logic        o_busy, o_byte_done, o_ack, o_ready;
   logic [7:0]  o_rx_byte;
   logic [63:0] o_cfg;
   logic [7:0]  tx_buf [10];
   logic [7:0]  rx_buf [10];
   logic        ack_buf [10];
   logic [7:0]  mon = 8'h00;
   logic        scl_p = 1'b1;
   logic        sda_p = 1'b1;
   int          mcnt = 8;
   int          nr = 0;
   int          cycles = 0;
   int          mismatches = 0;
   int          checks_done = 0;
   int          k;
   lcti_bus_if bus ();
   always #10 i_sys_clk = ~i_sys_clk;
   lcti_ctrl #(.HALF_CYC(4)) lcti_ctrl_inst (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_start(i_start), .i_tx_byte(i_tx_byte), .i_read(i_read),
      .i_last(i_last), .o_busy(o_busy), .o_byte_done(o_byte_done),
      .o_rx_byte(o_rx_byte), .o_ack(o_ack), .bus(bus));
   lcti_target #(.POR_CYC(10), .NUM_BYTES(8)) lcti_target_inst (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_config_source_select(i_config_source_select),
      .i_addr_sel(i_addr_sel), .o_cfg(o_cfg), .o_ready(o_ready),
      .bus(bus));
   lcti_bus_asserts #(.TADDR(TADDR)) lcti_bus_asserts_inst (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_config_source_select(i_config_source_select),
      .sda_oe(bus.sda_oe), .sda_t_o(bus.sda_t_o), .sda_t_oe(bus.sda_t_oe),
      .scl_t_oe(bus.scl_t_oe), .scl(bus.scl), .sda(bus.sda));
   // ========
   // wire monitor: first byte after start and clock pulse count
   always @(posedge i_sys_clk) begin
      scl_p <= bus.scl;
      sda_p <= bus.sda;
      if (scl_p && bus.scl && sda_p && !bus.sda) begin
         mcnt <= 0;
         nr <= 0;
      end else if (!scl_p && bus.scl) begin
         nr <= nr + 1;
         if (mcnt < 8) begin
            mon <= {mon[6:0], bus.sda};
            mcnt <= mcnt + 1;
         end
      end
   end
   task automatic complete_run();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   function automatic logic [7:0] pat(input int i);
      return 8'h3c + 8'h29 * i[7:0];
   endfunction
   // ========
   // one transfer: address byte then n bytes, inputs preset ahead
   task automatic xact(input logic [6:0] adr, input logic rd, input int n);
      int j;
      int w;
      i_tx_byte <= {adr, rd};
      i_read <= 1'b0;
      i_last <= (n == 0);
      i_start <= 1'b1;
      @(posedge i_sys_clk);
      i_start <= 1'b0;
      for (j = 0; j <= n; j++) begin
         if (j < n) begin
            i_tx_byte <= tx_buf[j];
            i_read <= rd;
            i_last <= (j == n - 1);
         end
         w = 0;
         do begin
            @(posedge i_sys_clk);
            w++;
         end while (o_byte_done !== 1'b1 && w < 400);
         if (w >= 400) mismatches++;
         rx_buf[j] = o_rx_byte;
         ack_buf[j] = o_ack;
      end
      w = 0;
      while (o_busy !== 1'b0 && w < 400) begin
         @(posedge i_sys_clk);
         w++;
      end
      if (w >= 400) mismatches++;
      `LCTI_CHK(mon, {adr, rd})
      `LCTI_CHK(nr, 9 * (n + 1) + 1)
      `LCTI_CHK({bus.scl, bus.sda}, 2'b11)
   endtask
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      `LCTI_CHK(o_ready, 1'b0)
      repeat (14) @(posedge i_sys_clk);
      `LCTI_CHK(o_ready, 1'b1)
      tx_buf[0] = 8'h00;
      for (k = 1; k < 9; k++) tx_buf[k] = pat(k - 1);
      xact(TADDR, 1'b0, 9);
      for (k = 0; k < 10; k++) `LCTI_CHK(ack_buf[k], 1'b1)
      for (k = 0; k < 8; k++) `LCTI_CHK(o_cfg[8*k+:8], pat(k))
      // freeze both ends mid-byte: no clock pulse, frame still intact
      fork
         xact(TADDR, 1'b0, 1);
         begin
            repeat (30) @(posedge i_sys_clk);
            i_ce <= 1'b0;
            repeat (3) @(posedge i_sys_clk);
            k = nr;
            repeat (17) @(posedge i_sys_clk);
            `LCTI_CHK(nr, k)
            i_ce <= 1'b1;
         end
      join
      xact(TADDR, 1'b1, 8);
      for (k = 1; k < 9; k++) begin
         `LCTI_CHK(rx_buf[k], pat(k - 1))
         `LCTI_CHK(ack_buf[k], k != 8)
      end
      tx_buf[0] = 8'h06;
      tx_buf[1] = 8'hc3;
      tx_buf[2] = 8'h96;
      tx_buf[3] = 8'h69;
      xact(TADDR, 1'b0, 4);
      `LCTI_CHK(ack_buf[4], 1'b1)
      `LCTI_CHK(o_cfg[63:48], 16'h96c3)
      `LCTI_CHK(o_cfg[7:0], pat(0))
      tx_buf[0] = 8'h07;
      xact(TADDR, 1'b0, 1);
      xact(TADDR, 1'b1, 2);
      `LCTI_CHK({rx_buf[1], rx_buf[2]}, 16'h9600)
      for (k = 0; k < 4; k++) begin
         xact(BAD[k], k[0], 0);
         `LCTI_CHK(ack_buf[0], 1'b0)
      end
      i_config_source_select <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
      xact(TADDR, 1'b0, 0);
      `LCTI_CHK(ack_buf[0], 1'b0)
      i_config_source_select <= 1'b1;
      repeat (14) @(posedge i_sys_clk);
      xact(TADDR, 1'b0, 0);
      `LCTI_CHK(ack_buf[0], 1'b1)
      complete_run();
   end
endmodule // tb
`default_nettype wire
